/* File: hw/power_path_pkg.sv */
// Constants, types and timing for the source power-path protection block
// What this block does
// RULE1 - Fast overvoltage: gate off first, then hard reset, then discharge.
// RULE2 - Fast trip level starts at 5 V, follows each new contract.
// RULE3 - Slow overvoltage armed after validation delay: hard reset, gate off, discharge.
// RULE4 - Slow overvoltage check ignored while raising VBUS to higher contract.
// RULE5 - Slow undervoltage armed after validation delay: hard reset, gate off, discharge.
// RULE6 - Slow undervoltage check ignored while lowering VBUS to lower contract.
// RULE7 - Overcurrent armed only after validation delay past first VBUS rise.
// RULE8 - Armed overcurrent trip latches breaker fault and turns main gate off.
// RULE9 - While armed, VBUS below falling threshold acts as overcurrent.
// RULE10 - Gate-disable falling edge overrides control and turns main gate off.
// RULE11 - Gate-disable low 600 ms after attach: hard reset, restart startup.
// RULE12 - Supply undervoltage over 600 ms after attach: fault, gate stays off.
// RULE13 - VBUS not above lockout 190 ms after gate on: fault, gate off.
// RULE14 - System raises supply within 275 ms, VBUS within 190 ms.
// RULE15 - Supply-select pins follow contract voltage: 5, 9/12, 15/20 V codes.
// RULE16 - Exactly one CC in window, debounced, VBUS low: attach indicator low.
// RULE17 - Attach indicator released after sink absent for debounce time.
// RULE18 - Logic rail output driven high when sink or accessory attached.
// RULE19 - Five volt path gate active only while sourcing 5 V.
// RULE20 - High voltage path gate active only while sourcing above 5 V.
// RULE21 - Delays counted in clock cycles from synchronized inputs; all but the CC attach/detach debounce cleared on restart.
// RULE22 - Hard reset and discharge are one-cycle strobes; gates off until restart.
package power_path_pkg;

    // ----------
    // Clock and timing
    // ----------
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS = 1000000;
    localparam int NS_PER_US = 1000;
    localparam int GD_HOLD_MS = 600;
    localparam int SUPPLY_HOLD_MS = 600;
    localparam int VBUS_RISE_MS = 190;
    localparam int CC_DEBOUNCE_US = 100;
    localparam int VALIDATE_US = 100;
    localparam int GD_HOLD_CYCLES =
        (GD_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUPPLY_HOLD_CYCLES =
        (SUPPLY_HOLD_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int VBUS_RISE_CYCLES =
        (VBUS_RISE_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int CC_DEBOUNCE_CYCLES =
        (CC_DEBOUNCE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VALIDATE_CYCLES =
        (VALIDATE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 25;

    // ----------
    // Synchronised input vector layout
    // ----------
    localparam int SY_CC1 = 0;
    localparam int SY_CC2 = 1;
    localparam int SY_VBUS_FTH = 2;
    localparam int SY_VBUS_RTH = 3;
    localparam int SY_VBUS_UVLO = 4;
    localparam int SY_SLOW_OV = 5;
    localparam int SY_SLOW_UV = 6;
    localparam int SY_FAST_OV = 7;
    localparam int SY_OCP = 8;
    localparam int SY_GD_N = 9;
    localparam int SY_SUPPLY_UV = 10;
    localparam int SY_W = 11;
    // Gate-disable idles high, so its stages reset high
    localparam logic [SY_W-1:0] SYNC_RST = 11'h200;

    // ----------
    // Types
    // ----------
    typedef enum logic [2:0] {
        V5, V9, V12, V15, V20
    } volt_t;

    typedef enum logic [3:0] {
        ST_UNATTACHED, ST_WAIT_SUPPLY, ST_POWERING, ST_SOURCING,
        ST_FAST_OFF, ST_FAST_HR, ST_SLOW_HR, ST_SLOW_OFF,
        ST_DSCG, ST_GD_HR, ST_LATCHED
    } pp_state_t;

    localparam volt_t VOLT_RST = V5;

    function automatic logic volt_above_five(input volt_t v);
        return v != V5;
    endfunction

    function automatic logic volt_top_pair(input volt_t v);
        return (v == V15) || (v == V20);
    endfunction

endpackage

/* File: hw/hold_timer.sv */
// Saturating hold timer: done once run has stayed high for LIMIT cycles
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
    parameter int W = 25,
    parameter int LIMIT = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic run_i,
    input wire logic clr_i,
    // Status
    output logic done_o
);
    localparam logic [W-1:0] LIM = W'(LIMIT);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_ff;

    // Any drop of run restarts the count, so the hold is continuous
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else if (clr_i || !run_i) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LIM) begin
            cnt_ff <= cnt_ff + ONE;
        end
    end

    assign done_o = run_i && !clr_i && (cnt_ff == LIM);
endmodule // hold_timer
`default_nettype wire

/* File: hw/power_path_protect.sv */
// Power-path sequencing and fault protection for a Type-C source port
`timescale 1ns/1ps
`default_nettype none
module power_path_protect
    import power_path_pkg::*;
#(
    parameter int GD_HOLD = GD_HOLD_CYCLES,
    parameter int SUPPLY_HOLD = SUPPLY_HOLD_CYCLES,
    parameter int VBUS_RISE = VBUS_RISE_CYCLES,
    parameter int CC_DEBOUNCE = CC_DEBOUNCE_CYCLES,
    parameter int VALIDATE = VALIDATE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Comparator inputs
    input wire logic cc1_in_window_i,
    input wire logic cc2_in_window_i,
    input wire logic vbus_below_fth_i,
    input wire logic vbus_above_rth_i,
    input wire logic vbus_above_uvlo_i,
    input wire logic vbus_slow_ov_i,
    input wire logic vbus_slow_uv_i,
    input wire logic vbus_fast_ov_i,
    input wire logic current_sense_in_i,
    input wire logic high_volt_supply_in_uv_i,
    // System inputs
    input wire logic gate_disable_n_i,
    input wire logic accessory_attached_i,
    // Protocol engine
    input wire logic contract_load_i,
    input wire volt_t contract_volt_i,
    input wire logic raising_vbus_i,
    input wire logic lowering_vbus_i,
    output logic hard_reset_req_o,
    output logic discharge_req_o,
    // Gate drivers
    output logic main_nfet_gate_o,
    output logic five_volt_path_gate_o,
    output logic high_volt_pfet_gate_o,
    output volt_t fast_ovp_level_o,
    // Open-drain supply select and attach pins
    output logic supply_select_lo_o,
    output logic supply_select_lo_oe_o,
    output logic supply_select_hi_o,
    output logic supply_select_hi_oe_o,
    output logic sink_attached_n_o,
    output logic sink_attached_n_oe_o,
    output logic logic_rail_attach_out_o,
    output logic logic_rail_attach_out_oe_o,
    // Fault flags
    output logic overvoltage_fault_o,
    output logic breaker_fault_o,
    output logic supply_fault_o,
    output logic rise_timeout_fault_o
);

    // ----------
    // Input synchronisers
    // ----------
    logic [SY_W-1:0] raw_in;
    logic [SY_W-1:0] sync1_ff;
    logic [SY_W-1:0] sync2_ff;
    logic gd_n_d_ff;

    assign raw_in = {high_volt_supply_in_uv_i, gate_disable_n_i,
                     current_sense_in_i, vbus_fast_ov_i, vbus_slow_uv_i,
                     vbus_slow_ov_i, vbus_above_uvlo_i, vbus_above_rth_i,
                     vbus_below_fth_i, cc2_in_window_i, cc1_in_window_i};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
            gd_n_d_ff <= 1'b1;
        end else begin
            sync1_ff <= raw_in; // RULE21
            sync2_ff <= sync1_ff;
            gd_n_d_ff <= sync2_ff[SY_GD_N];
        end
    end

    logic cc_one;
    logic vbus_fth;
    logic gd_low;
    logic gd_fall;

    assign cc_one = sync2_ff[SY_CC1] ^ sync2_ff[SY_CC2];
    assign vbus_fth = sync2_ff[SY_VBUS_FTH];
    assign gd_low = !sync2_ff[SY_GD_N];
    assign gd_fall = gd_n_d_ff && gd_low;

    // ----------
    // State and timers
    // ----------
    pp_state_t state_ff;
    pp_state_t nxt_state;
    logic attached_ff;
    logic main_gate_ff;
    logic rose_ff;
    logic restart;
    logic attach_done;
    logic detach_done;
    logic gd_done;
    logic supply_done;
    logic rise_done;
    logic validate_done;
    logic ocp_armed;

    assign restart = (state_ff == ST_UNATTACHED) || (state_ff == ST_GD_HR);

    hold_timer #(.W(TMR_W), .LIMIT(CC_DEBOUNCE)) u_attach_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(cc_one && vbus_fth && !attached_ff), // RULE16
        .clr_i(1'b0),
        .done_o(attach_done)
    );

    hold_timer #(.W(TMR_W), .LIMIT(CC_DEBOUNCE)) u_detach_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(!cc_one && attached_ff), // RULE17
        .clr_i(1'b0),
        .done_o(detach_done)
    );

    hold_timer #(.W(TMR_W), .LIMIT(GD_HOLD)) u_gd_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(gd_low && (state_ff == ST_WAIT_SUPPLY)), // RULE11
        .clr_i(restart), // RULE21
        .done_o(gd_done)
    );

    hold_timer #(.W(TMR_W), .LIMIT(SUPPLY_HOLD)) u_supply_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(sync2_ff[SY_SUPPLY_UV] && attached_ff), // RULE12
        .clr_i(restart),
        .done_o(supply_done)
    );

    hold_timer #(.W(TMR_W), .LIMIT(VBUS_RISE)) u_rise_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(state_ff == ST_POWERING), // RULE13
        .clr_i(restart),
        .done_o(rise_done)
    );

    hold_timer #(.W(TMR_W), .LIMIT(VALIDATE)) u_validate_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(main_gate_ff), // RULE3 RULE5
        .clr_i(restart),
        .done_o(validate_done)
    );

    hold_timer #(.W(TMR_W), .LIMIT(VALIDATE)) u_ocp_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(rose_ff), // RULE7
        .clr_i(restart),
        .done_o(ocp_armed)
    );

    // ----------
    // Attach tracking
    // ----------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            attached_ff <= 1'b0;
        end else if (attach_done) begin
            attached_ff <= 1'b1; // RULE16
        end else if (detach_done) begin
            attached_ff <= 1'b0; // RULE17
        end
    end

    // First VBUS rise while the main gate is on starts the arming delay
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rose_ff <= 1'b0;
        end else if (restart || !main_gate_ff) begin
            rose_ff <= 1'b0;
        end else if (sync2_ff[SY_VBUS_RTH]) begin
            rose_ff <= 1'b1; // RULE7
        end
    end

    // ----------
    // Sequencer
    // ----------
    logic slow_active;
    logic slow_ov;
    logic slow_uv;
    logic ocp_event;

    assign slow_active = validate_done && (state_ff == ST_SOURCING);
    assign slow_ov = slow_active && sync2_ff[SY_SLOW_OV] &&
                     !raising_vbus_i; // RULE3 RULE4
    assign slow_uv = slow_active && sync2_ff[SY_SLOW_UV] &&
                     !lowering_vbus_i; // RULE5 RULE6
    assign ocp_event = ocp_armed &&
                       (sync2_ff[SY_OCP] || vbus_fth); // RULE8 RULE9

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_UNATTACHED: begin
                if (attached_ff) begin
                    nxt_state = ST_WAIT_SUPPLY;
                end
            end
            ST_WAIT_SUPPLY: begin
                if (gd_done) begin
                    nxt_state = ST_GD_HR; // RULE11
                end else if (supply_done) begin
                    nxt_state = ST_LATCHED; // RULE12
                end else if (!gd_low && !sync2_ff[SY_SUPPLY_UV]) begin
                    nxt_state = ST_POWERING;
                end
            end
            ST_POWERING, ST_SOURCING: begin
                if (sync2_ff[SY_FAST_OV]) begin
                    nxt_state = ST_FAST_OFF; // RULE1
                end else if (gd_low) begin
                    nxt_state = ST_WAIT_SUPPLY; // RULE10
                end else if (ocp_event) begin
                    nxt_state = ST_LATCHED; // RULE8
                end else if (slow_ov || slow_uv) begin
                    nxt_state = ST_SLOW_HR; // RULE3 RULE5
                end else if (state_ff == ST_POWERING) begin
                    if (rise_done) begin
                        nxt_state = ST_LATCHED; // RULE13
                    end else if (sync2_ff[SY_VBUS_UVLO]) begin
                        nxt_state = ST_SOURCING;
                    end
                end
            end
            ST_FAST_OFF: nxt_state = ST_FAST_HR; // RULE1
            ST_FAST_HR: nxt_state = ST_DSCG;
            ST_SLOW_HR: nxt_state = ST_SLOW_OFF; // RULE3 RULE5
            ST_SLOW_OFF: nxt_state = ST_DSCG;
            ST_DSCG: nxt_state = ST_LATCHED;
            ST_GD_HR: nxt_state = ST_WAIT_SUPPLY; // RULE11
            ST_LATCHED: nxt_state = ST_LATCHED; // RULE22
        endcase
        // Detach ends every sequence and restarts from scratch
        if (!attached_ff) begin
            nxt_state = ST_UNATTACHED;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_UNATTACHED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------
    // Contract voltage and fast trip level
    // ----------
    volt_t volt_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            volt_ff <= VOLT_RST; // RULE2
        end else if (contract_load_i) begin
            volt_ff <= contract_volt_i; // RULE2
        end else if (restart && (state_ff == ST_UNATTACHED)) begin
            volt_ff <= VOLT_RST;
        end
    end

    // ----------
    // Gate drivers
    // ----------
    logic nxt_gate;

    // Gate-disable gates the drive directly so an edge never waits on states
    assign nxt_gate = !gd_low && !gd_fall && !ocp_event &&
                      ((nxt_state == ST_POWERING) ||
                       (nxt_state == ST_SOURCING) ||
                       (nxt_state == ST_SLOW_HR)); // RULE10 RULE22

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_gate_ff <= 1'b0;
            five_volt_path_gate_o <= 1'b0;
            high_volt_pfet_gate_o <= 1'b0;
        end else begin
            main_gate_ff <= nxt_gate; // RULE1 RULE8 RULE13
            five_volt_path_gate_o <= nxt_gate &&
                                     !volt_above_five(volt_ff); // RULE19
            high_volt_pfet_gate_o <= nxt_gate &&
                                     volt_above_five(volt_ff); // RULE20
        end
    end

    assign main_nfet_gate_o = main_gate_ff;

    // ----------
    // Strobes to protocol and discharge units
    // ----------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hard_reset_req_o <= 1'b0;
            discharge_req_o <= 1'b0;
        end else begin
            hard_reset_req_o <= (nxt_state == ST_FAST_HR) ||
                                (nxt_state == ST_SLOW_HR) ||
                                (nxt_state == ST_GD_HR); // RULE22
            discharge_req_o <= (nxt_state == ST_DSCG); // RULE22
        end
    end

    // ----------
    // Pins and indicators
    // ----------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fast_ovp_level_o <= VOLT_RST;
            supply_select_hi_oe_o <= 1'b0;
            supply_select_lo_oe_o <= 1'b0;
            sink_attached_n_oe_o <= 1'b0;
            logic_rail_attach_out_oe_o <= 1'b0;
        end else begin
            fast_ovp_level_o <= volt_ff; // RULE2
            supply_select_hi_oe_o <= volt_above_five(volt_ff); // RULE15
            supply_select_lo_oe_o <= volt_top_pair(volt_ff); // RULE15
            sink_attached_n_oe_o <= attached_ff; // RULE16 RULE17
            logic_rail_attach_out_oe_o <= attached_ff ||
                                          accessory_attached_i; // RULE18
        end
    end

    // Open-drain pins only ever pull low; the rail pin only drives high
    assign supply_select_hi_o = 1'b0;
    assign supply_select_lo_o = 1'b0;
    assign sink_attached_n_o = 1'b0;
    assign logic_rail_attach_out_o = 1'b1;

    // ----------
    // Fault flags, cleared only by a fresh attach cycle
    // ----------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overvoltage_fault_o <= 1'b0;
            breaker_fault_o <= 1'b0;
            supply_fault_o <= 1'b0;
            rise_timeout_fault_o <= 1'b0;
        end else begin
            if (nxt_state == ST_FAST_OFF || nxt_state == ST_SLOW_HR) begin
                overvoltage_fault_o <= 1'b1;
            end else if (state_ff == ST_UNATTACHED) begin
                overvoltage_fault_o <= 1'b0;
            end
            if (ocp_event && (state_ff == ST_POWERING ||
                              state_ff == ST_SOURCING)) begin
                breaker_fault_o <= 1'b1; // RULE8
            end else if (state_ff == ST_UNATTACHED) begin
                breaker_fault_o <= 1'b0;
            end
            if (supply_done && state_ff == ST_WAIT_SUPPLY) begin
                supply_fault_o <= 1'b1; // RULE12
            end else if (state_ff == ST_UNATTACHED) begin
                supply_fault_o <= 1'b0;
            end
            if (rise_done && nxt_state == ST_LATCHED) begin
                rise_timeout_fault_o <= 1'b1; // RULE13
            end else if (state_ff == ST_UNATTACHED) begin
                rise_timeout_fault_o <= 1'b0;
            end
        end
    end

endmodule // power_path_protect
`default_nettype wire

/* File: verification/power_path_monitor.sv */
// Port-level assertion checker for the power-path protection block
`timescale 1ns/1ps
`default_nettype none
module power_path_monitor
    import power_path_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Inputs watched
    input wire logic vbus_fast_ov_i,
    input wire logic gate_disable_n_i,
    // Outputs watched
    input wire logic hard_reset_req_o,
    input wire logic discharge_req_o,
    input wire logic main_nfet_gate_o,
    input wire logic five_volt_path_gate_o,
    input wire logic high_volt_pfet_gate_o,
    input wire volt_t fast_ovp_level_o,
    input wire logic supply_select_lo_oe_o,
    input wire logic supply_select_hi_oe_o,
    input wire logic sink_attached_n_oe_o,
    input wire logic logic_rail_attach_out_oe_o,
    input wire logic breaker_fault_o,
    input wire logic supply_fault_o,
    input wire logic rise_timeout_fault_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Sync latency is two or three edges depending on input phase
    a_fast_ov_order: assert property (
        $rose(vbus_fast_ov_i) && main_nfet_gate_o && gate_disable_n_i
        |-> ##[2:3] !main_nfet_gate_o ##1 hard_reset_req_o
        ##1 discharge_req_o) else $error("fast trip order broken");
    a_slow_hr_first: assert property (
        $rose(hard_reset_req_o) && main_nfet_gate_o
        |=> !main_nfet_gate_o ##1 discharge_req_o)
        else $error("slow trip order broken");
    a_hr_one_cycle: assert property (
        hard_reset_req_o |=> !hard_reset_req_o)
        else $error("hard reset not a pulse");
    a_dsc_one_cycle: assert property (
        discharge_req_o |=> !discharge_req_o)
        else $error("discharge not a pulse");
    a_gd_gate_off: assert property (
        $fell(gate_disable_n_i) ##1 !gate_disable_n_i [*2]
        |=> !main_nfet_gate_o) else $error("gate stayed on");
    a_breaker_off: assert property (
        breaker_fault_o |-> !main_nfet_gate_o && !discharge_req_o)
        else $error("breaker gate on");
    a_fault_gate_off: assert property (
        (supply_fault_o || rise_timeout_fault_o) |=> !main_nfet_gate_o)
        else $error("fault gate on");
    a_select_code: assert property (
        supply_select_hi_oe_o == (fast_ovp_level_o != V5) &&
        supply_select_lo_oe_o == (fast_ovp_level_o inside {V15, V20}))
        else $error("supply select code wrong");
    a_path_gates: assert property (
        (five_volt_path_gate_o || high_volt_pfet_gate_o) |->
        main_nfet_gate_o &&
        high_volt_pfet_gate_o != five_volt_path_gate_o &&
        five_volt_path_gate_o == (fast_ovp_level_o == V5))
        else $error("path gate wrong");
    a_rail_attach: assert property (
        sink_attached_n_oe_o |-> logic_rail_attach_out_oe_o)
        else $error("rail not driven on attach");
endmodule // power_path_monitor

bind power_path_protect power_path_monitor i_power_path_monitor (.*);
`default_nettype wire

/* File: verification/sink_model.sv */
// Behavioural sink seen through the CC and VBUS comparators
`timescale 1ns/1ps
`default_nettype none
module sink_model #(
    parameter int RISE = 4
) (
    // Clock
    input wire logic clk_i,
    // Bench control
    input wire logic plug_i,
    input wire logic sag_i,
    // Source side
    input wire logic gate_i,
    // Comparator view
    output logic cc1_o,
    output logic cc2_o,
    output logic below_fth_o,
    output logic above_rth_o,
    output logic above_uvlo_o
);
    int cnt = 0;
    logic up;
    // Rail ramps behind the gate; sag holds it down, gate off drains it
    always @(posedge clk_i) begin
        if (!gate_i || sag_i) cnt <= 0;
        else if (cnt < RISE) cnt <= cnt + 1;
    end
    assign up = (cnt >= RISE);
    assign cc1_o = plug_i;
    assign cc2_o = 1'b0;
    assign below_fth_o = !up;
    assign above_rth_o = up;
    assign above_uvlo_o = up;
endmodule // sink_model
`default_nettype wire

/* File: verification/test_power_path_protect.sv */
// Self-checking bench for the power-path protection block
`timescale 1ns/1ps
`default_nettype none
module test_power_path_protect;
    import power_path_pkg::*;
    logic clk_i = 0, rst_n_i = 0, plug = 0, sag = 0, fov = 0, sov = 0;
    logic suv = 0, ocp = 0, puv = 0, gd_n = 1, acc = 0, load = 0;
    logic raise = 0, lower = 0;
    volt_t volt = V5;
    volt_t lvl;
    logic cc1, cc2, bfth, arth, auvlo, hr, dc, gate, g5, ghv, ovf, brk;
    logic slo_oe, shi_oe, att_oe, rail_oe, spf, rtf;
    int bad_count = 0, n_tests = 0, hr_n = 0, dc_n = 0, cyc_n = 0;

    power_path_protect #(.GD_HOLD(40), .SUPPLY_HOLD(40), .VBUS_RISE(30),
        .CC_DEBOUNCE(10), .VALIDATE(10)) i_power_path_protect (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cc1_in_window_i(cc1),
        .cc2_in_window_i(cc2), .vbus_below_fth_i(bfth),
        .vbus_above_rth_i(arth), .vbus_above_uvlo_i(auvlo),
        .vbus_slow_ov_i(sov), .vbus_slow_uv_i(suv), .vbus_fast_ov_i(fov),
        .current_sense_in_i(ocp), .high_volt_supply_in_uv_i(puv),
        .gate_disable_n_i(gd_n), .accessory_attached_i(acc),
        .contract_load_i(load), .contract_volt_i(volt),
        .raising_vbus_i(raise), .lowering_vbus_i(lower),
        .hard_reset_req_o(hr), .discharge_req_o(dc),
        .main_nfet_gate_o(gate), .five_volt_path_gate_o(g5),
        .high_volt_pfet_gate_o(ghv), .fast_ovp_level_o(lvl),
        .supply_select_lo_o(), .supply_select_lo_oe_o(slo_oe),
        .supply_select_hi_o(), .supply_select_hi_oe_o(shi_oe),
        .sink_attached_n_o(), .sink_attached_n_oe_o(att_oe),
        .logic_rail_attach_out_o(), .logic_rail_attach_out_oe_o(rail_oe),
        .overvoltage_fault_o(ovf), .breaker_fault_o(brk),
        .supply_fault_o(spf), .rise_timeout_fault_o(rtf));
    sink_model i_sink_model (.clk_i(clk_i), .plug_i(plug), .sag_i(sag),
        .gate_i(gate), .cc1_o(cc1), .cc2_o(cc2), .below_fth_o(bfth),
        .above_rth_o(arth), .above_uvlo_o(auvlo));

    always #12.5 clk_i = ~clk_i;
    // Strobes last one cycle, so they are counted rather than sampled
    always @(posedge clk_i) begin
        if (hr) hr_n++;
        if (dc) dc_n++;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input string s, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %b got %b", s, e, g);
        end
    endtask
    task automatic chkv(input string s, input volt_t e, input volt_t g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %0d got %0d", s, e, g);
        end
    endtask
    task automatic wait_gate();
        for (int i = 0; i < 100 && gate !== 1'b1; i++) cyc(1);
        chk("gate_on", 1'b1, gate);
    endtask
    task automatic up();
        plug = 1;
        wait_gate();
        cyc(25);
        hr_n = 0;
        dc_n = 0;
    endtask
    task automatic down(input string s);
        {plug, sag, fov, sov, suv, ocp, puv, raise, lower} = '0;
        cyc(5);
        chk("attach_hold", 1'b1, att_oe);
        cyc(25);
        chk("attach_drop", 1'b0, att_oe);
        $display("test %s done", s);
    endtask

    task automatic t_reset();
        chkv("level", V5, lvl);
        chk("gate", 1'b0, gate);
        chk("rail", 1'b0, rail_oe);
        acc = 1;
        cyc(4);
        chk("rail_acc", 1'b1, rail_oe);
        acc = 0;
        cyc(4);
        $display("test reset done");
    endtask
    task automatic t_contract();
        plug = 1;
        cyc(8);
        chk("early", 1'b0, att_oe);
        wait_gate();
        chk("attach", 1'b1, att_oe);
        chk("rail", 1'b1, rail_oe);
        cyc(25);
        for (int v = 4; v >= 0; v--) begin
            volt = volt_t'(v);
            load = 1;
            cyc(1);
            load = 0;
            cyc(2);
            chkv("level", volt, lvl);
            chk("sel_hi", v != 0, shi_oe);
            chk("sel_lo", v >= 3, slo_oe);
            chk("g5", v == 0, g5);
            chk("ghv", v != 0, ghv);
        end
        down("contract");
    endtask
    task automatic t_fast();
        up();
        fov = 1;
        cyc(8);
        chk("ov_fault", 1'b1, ovf);
        chk("gate", 1'b0, gate);
        chk("hr_count", hr_n == 1, 1'b1);
        chk("dc_count", dc_n == 1, 1'b1);
        down("fast_ov");
    endtask
    task automatic t_slow(input logic uv);
        up();
        raise = !uv;
        lower = uv;
        sov = !uv;
        suv = uv;
        cyc(10);
        chk("held", 1'b1, gate);
        chk("hr_none", hr_n == 0, 1'b1);
        {raise, lower} = 2'h0;
        cyc(8);
        chk("hr_count", hr_n == 1, 1'b1);
        chk("dc_count", dc_n == 1, 1'b1);
        chk("gate", 1'b0, gate);
        down(uv ? "slow_uv" : "slow_ov");
    endtask
    task automatic t_ocp();
        hr_n = 0;
        ocp = 1;
        plug = 1;
        wait_gate();
        chk("brk_early", 1'b0, brk);
        cyc(30);
        chk("brk", 1'b1, brk);
        chk("gate", 1'b0, gate);
        chk("no_hr", hr_n == 0, 1'b1);
        down("ocp");
        up();
        sag = 1;
        cyc(8);
        chk("brk_sag", 1'b1, brk);
        down("vbus_sag");
    endtask
    task automatic t_gd();
        up();
        gd_n = 0;
        cyc(4);
        chk("gate_off", 1'b0, gate);
        cyc(50);
        chk("hr_gd", hr_n == 1, 1'b1);
        chk("kept", 1'b1, att_oe);
        gd_n = 1;
        wait_gate();
        down("gate_disable");
    endtask
    task automatic t_faults();
        puv = 1;
        plug = 1;
        cyc(70);
        chk("sup_fault", 1'b1, spf);
        chk("gate", 1'b0, gate);
        down("supply");
        sag = 1;
        plug = 1;
        wait_gate();
        cyc(40);
        chk("rise_fault", 1'b1, rtf);
        chk("gate", 1'b0, gate);
        down("rise");
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1;
        cyc(2);
        t_reset();
        t_contract();
        t_fast();
        t_slow(1'b0);
        t_slow(1'b1);
        t_ocp();
        t_gd();
        t_faults();
        complete_run();
    end
endmodule // test_power_path_protect
`default_nettype wire
